// ---- design/lcdc_pkg.sv ----
/*
  Shared constants and types for the segment LCD command front end.
  Assumes one system clock domain and one link (display) clock domain.
*/
package lcdc_pkg;
  // Slave address: upper six bits fixed, low bit from the strap
  localparam logic [5:0] SLAVE_ADDR_HI   = 6'h1C;
  localparam logic [3:0] BYTE_BITS       = 4'h8;
  localparam int         CONT_BIT        = 7;
  // Opcode fields below the continuation flag
  localparam logic [1:0] OP_MODE_SET     = 2'h2;
  localparam logic [1:0] OP_LOAD_PTR     = 2'h0;
  localparam logic [3:0] OP_DEV_SELECT   = 4'hC;
  localparam logic [3:0] OP_BLINK_SELECT = 4'hE;
  localparam logic [4:0] OP_BANK_SELECT  = 5'h1E;
  // Field positions
  localparam int         MS_EN_BIT       = 3;
  localparam int         MS_BIAS_BIT     = 2;
  localparam int         BANK_IN_BIT     = 1;
  localparam int         BANK_OUT_BIT    = 0;
  localparam int         BLINK_ALT_BIT   = 2;
  // Drive modes
  localparam logic [1:0] DRIVE_STATIC    = 2'h1;
  localparam logic [1:0] DRIVE_DUPLEX    = 2'h2;
  localparam logic [1:0] DRIVE_TRIPLEX   = 2'h3;
  localparam logic [1:0] DRIVE_QUAD      = 2'h0;
  // RAM addresses filled per display byte, per drive mode
  localparam logic [5:0] STEP_STATIC     = 6'h08;
  localparam logic [5:0] STEP_DUPLEX     = 6'h04;
  localparam logic [5:0] STEP_TRIPLEX    = 6'h03;
  localparam logic [5:0] STEP_QUAD       = 6'h02;
  // Values after reset
  localparam logic [1:0] RST_DRIVE_MODE  = 2'h0;
  localparam logic [4:0] RST_DATA_PTR    = 5'h00;
  localparam logic [2:0] RST_SUBADDR     = 3'h0;
  localparam logic [1:0] RST_BLINK_RATE  = 2'h0;
  localparam int         FIFO_DEPTH      = 4;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_ADDR   = 5'b00010,
    ST_CMD    = 5'b00100,
    ST_DATA   = 5'b01000,
    ST_IGNORE = 5'b10000
  } lcdc_state_type;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] data;
    logic       in_bank;
    logic [1:0] drive_mode;
  } lcdc_ram_wr_type;

  localparam int RAM_WR_BITS = $bits(lcdc_ram_wr_type);
endpackage

// ---- design/lcdc_fifo.sv ----
/*
  Single-clock FIFO with valid/ready on both sides.
  Assumes DEPTH is a power of two and both sides share the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lcdc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_sys_rst,
  // Fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ptr_ff;
  logic [AW:0]      rd_ptr_ff;
  wire              full  = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  wire              empty = (wr_ptr_ff == rd_ptr_ff);
  wire              push  = i_in_valid && !full;
  wire              pop   = !empty && i_out_ready;

  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem_ff[rd_ptr_ff[AW-1:0]];

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end
endmodule // lcdc_fifo
`default_nettype wire

// ---- design/lcdc_link_wr.sv ----
/*
  Link-domain end of the RAM write crossing: toggle request in, toggle ack out.
  Assumes the word stays stable from the request toggle until the ack returns.
*/
`timescale 1ns/1ps
`default_nettype none
module lcdc_link_wr
  import lcdc_pkg::*;
(
  // Link clock and reset
  input  wire logic            i_clk_link,
  input  wire logic            i_link_rst,
  // From the system domain
  input  wire logic            i_req_tgl,
  input  wire lcdc_ram_wr_type i_word,
  output logic                 o_ack_tgl,
  // Display RAM write port
  output logic                 o_ram_we,
  output lcdc_ram_wr_type      o_ram_word
);
  logic req_s1_ff;
  logic req_s2_ff;
  logic req_d_ff;
  wire  req_new = req_s2_ff ^ req_d_ff;

  always_ff @(posedge i_clk_link) begin
    if (i_link_rst) begin
      req_s1_ff  <= 1'b0;
      req_s2_ff  <= 1'b0;
      req_d_ff   <= 1'b0;
      o_ack_tgl  <= 1'b0;
      o_ram_we   <= 1'b0;
      o_ram_word <= '0;
    end else begin
      req_s1_ff <= i_req_tgl;
      req_s2_ff <= req_s1_ff;
      req_d_ff  <= req_s2_ff;
      o_ram_we  <= req_new;
      if (req_new) begin
        o_ram_word <= i_word;
        o_ack_tgl  <= req_s2_ff;
      end
    end
  end
endmodule // lcdc_link_wr
`default_nettype wire

// ---- design/lcdc_decoder.sv ----
/*
  Write-only two-wire slave and command decoder of a segment LCD driver.
  Assumes bus pins and straps are asynchronous; RAM writes run on the link clock.
*/
// How it works
// - Answer only 0111 00x with x from strap
// - Read requests are never acknowledged
// - Mismatched address ignores transfer until next START
// - Every command byte after a hit is acknowledged
// - Bit 7 chains commands, clear starts data
// - Data goes to pointer address, pointer auto-advances
// - Data acknowledged only when subaddress counter matches pins
// - STOP or repeated START both end a transfer
// - Mode-set sets display enable, bit 4 ignored
// - Mode-set also sets bias and drive mode
// - Load-data-pointer copies five bits to pointer
// - Device-select loads three-bit subaddress counter
// - Opcode bits below flag classify each command
// - Bank-select sets banks, ignored in 3/4 backplanes
// - Blink-select; alternate bank becomes normal in 3/4
// - Mismatch inhibits write, pointer advances, overflow bumps counter
`timescale 1ns/1ps
`default_nettype none
module lcdc_decoder
  import lcdc_pkg::*;
(
  // System clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  // Link clock and reset
  input  wire logic       i_clk_link,
  input  wire logic       i_link_rst,
  // Bus pins
  input  wire logic       i_scl,
  output logic            o_scl_o,
  output logic            o_scl_oe,
  input  wire logic       i_sda,
  output logic            o_sda_o,
  output logic            o_sda_oe,
  // Straps
  input  wire logic       i_addr_low_bit_strap,
  input  wire logic       i_hw_subaddr_pin_bit0,
  input  wire logic       i_hw_subaddr_pin_bit1,
  input  wire logic       i_hw_subaddr_pin_bit2,
  // Decoded status
  output logic            o_display_en,
  output logic            o_bias_half,
  output logic [1:0]      o_drive_mode,
  output logic            o_in_bank,
  output logic            o_out_bank,
  output logic            o_blink_alt,
  output logic [1:0]      o_blink_rate_field,
  output logic [4:0]      o_data_ptr,
  output logic [2:0]      o_subaddr_cnt,
  output logic            o_selected,
  // Display RAM write, link domain
  output logic            o_ram_we,
  output lcdc_ram_wr_type o_ram_word
);
  // Pin synchronisers
  logic [5:0]     pins_s1_ff;
  logic [5:0]     pins_s2_ff;
  logic           scl_d_ff;
  logic           sda_d_ff;
  // Byte engine
  lcdc_state_type st_ff;
  logic [3:0]     bit_cnt_ff;
  logic [7:0]     shift_ff;
  logic           pend_ff;
  logic           ack_ff;
  // Byte already executed; the next SCL fall closes its ack slot
  logic           taken_ff;
  // Decoded state
  logic           disp_en_ff;
  logic           bias_ff;
  logic [1:0]     mode_ff;
  logic           in_bank_ff;
  logic           out_bank_ff;
  logic           blink_alt_ff;
  logic           blink_alt_eff_ff;
  logic [1:0]     blink_rate_ff;
  logic [4:0]     ptr_ff;
  logic [2:0]     sub_ff;
  // Crossing to the link domain
  lcdc_ram_wr_type hold_ff;
  logic           req_ff;
  logic           ack_s1_ff;
  logic           ack_s2_ff;
  logic           link_ack_tgl;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      pins_s1_ff <= 6'h3F;
      pins_s2_ff <= 6'h3F;
      scl_d_ff   <= 1'b1;
      sda_d_ff   <= 1'b1;
    end else begin
      pins_s1_ff <= {i_hw_subaddr_pin_bit2, i_hw_subaddr_pin_bit1, i_hw_subaddr_pin_bit0,
                     i_addr_low_bit_strap, i_sda, i_scl};
      pins_s2_ff <= pins_s1_ff;
      scl_d_ff   <= pins_s2_ff[0];
      sda_d_ff   <= pins_s2_ff[1];
    end
  end

  wire       scl      = pins_s2_ff[0];
  wire       sda      = pins_s2_ff[1];
  wire       strap    = pins_s2_ff[2];
  wire [2:0] hw_sub   = pins_s2_ff[5:3];
  wire       start_ev = scl && scl_d_ff && sda_d_ff && !sda;
  wire       stop_ev  = scl && scl_d_ff && !sda_d_ff && sda;
  wire       scl_rise = scl && !scl_d_ff;
  wire       scl_fall = !scl && scl_d_ff;
  wire       in_byte  = (st_ff == ST_ADDR) || (st_ff == ST_CMD) || (st_ff == ST_DATA);

  // Classification of the held byte
  wire addr_hit    = (shift_ff[7:2] == SLAVE_ADDR_HI) && (shift_ff[1] == strap);
  wire addr_write  = !shift_ff[0];
  wire is_mode_set = (shift_ff[6:5] == OP_MODE_SET);
  wire is_load_ptr = (shift_ff[6:5] == OP_LOAD_PTR);
  wire is_dev_sel  = (shift_ff[6:3] == OP_DEV_SELECT);
  wire is_blink    = (shift_ff[6:3] == OP_BLINK_SELECT);
  wire is_bank     = (shift_ff[6:2] == OP_BANK_SELECT);
  wire low_mux     = (mode_ff == DRIVE_STATIC) || (mode_ff == DRIVE_DUPLEX);
  wire sub_match   = (sub_ff == hw_sub);

  // Pointer stepping and overflow into the subaddress counter
  wire [5:0] ptr_step = (mode_ff == DRIVE_STATIC)  ? STEP_STATIC :
                        (mode_ff == DRIVE_DUPLEX)  ? STEP_DUPLEX :
                        (mode_ff == DRIVE_TRIPLEX) ? STEP_TRIPLEX : STEP_QUAD;
  wire [5:0] ptr_sum  = {1'b0, ptr_ff} + ptr_step;

  // FIFO between byte engine and crossing
  logic            fifo_in_ready;
  logic            fifo_out_valid;
  logic [RAM_WR_BITS-1:0] fifo_out_data;
  wire             xfer_busy  = (req_ff != ack_s2_ff);
  wire             fifo_pop   = fifo_out_valid && !xfer_busy;
  wire             data_store = (st_ff == ST_DATA) && sub_match;
  // Stretch the clock while a matching data byte cannot be queued
  wire             exec       = pend_ff && !(data_store && !fifo_in_ready);
  wire             fifo_push  = exec && data_store;
  lcdc_ram_wr_type push_word;

  assign push_word = '{addr: ptr_ff, data: shift_ff, in_bank: in_bank_ff, drive_mode: mode_ff};

  // Byte engine
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_ff      <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff   <= 8'h00;
      pend_ff    <= 1'b0;
      ack_ff     <= 1'b0;
      taken_ff   <= 1'b0;
    end else if (start_ev || stop_ev) begin
      st_ff      <= start_ev ? ST_ADDR : ST_IDLE;
      bit_cnt_ff <= 4'h0;
      pend_ff    <= 1'b0;
      ack_ff     <= 1'b0;
      taken_ff   <= 1'b0;
    end else if (exec) begin
      pend_ff  <= 1'b0;
      taken_ff <= 1'b1;
      case (st_ff)
        ST_ADDR: begin
          ack_ff <= addr_hit && addr_write;
          st_ff  <= (addr_hit && addr_write) ? ST_CMD : ST_IGNORE;
        end
        ST_CMD: begin
          ack_ff <= 1'b1;
          st_ff  <= shift_ff[CONT_BIT] ? ST_CMD : ST_DATA;
        end
        ST_DATA: begin
          ack_ff <= sub_match;
        end
        default: begin
          ack_ff <= 1'b0;
        end
      endcase
    end else if (in_byte && scl_rise && (bit_cnt_ff != BYTE_BITS)) begin
      shift_ff   <= {shift_ff[6:0], sda};
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    end else if (in_byte && scl_fall && (bit_cnt_ff == BYTE_BITS)) begin
      if (taken_ff) begin
        ack_ff     <= 1'b0;
        taken_ff   <= 1'b0;
        bit_cnt_ff <= 4'h0;
      end else if (!pend_ff) begin
        pend_ff <= 1'b1;
      end
    end
  end

  // Command execution
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      disp_en_ff    <= 1'b0;
      bias_ff       <= 1'b0;
      mode_ff       <= RST_DRIVE_MODE;
      in_bank_ff    <= 1'b0;
      out_bank_ff   <= 1'b0;
      blink_alt_ff  <= 1'b0;
      blink_rate_ff <= RST_BLINK_RATE;
      ptr_ff        <= RST_DATA_PTR;
      sub_ff        <= RST_SUBADDR;
    end else if (exec && (st_ff == ST_CMD)) begin
      if (is_mode_set) begin
        disp_en_ff <= shift_ff[MS_EN_BIT];
        bias_ff    <= shift_ff[MS_BIAS_BIT];
        mode_ff    <= shift_ff[1:0];
      end
      if (is_load_ptr) ptr_ff <= shift_ff[4:0];
      if (is_dev_sel) sub_ff <= shift_ff[2:0];
      if (is_bank && low_mux) begin
        in_bank_ff  <= shift_ff[BANK_IN_BIT];
        out_bank_ff <= shift_ff[BANK_OUT_BIT];
      end
      if (is_blink) begin
        blink_alt_ff  <= shift_ff[BLINK_ALT_BIT];
        blink_rate_ff <= shift_ff[1:0];
      end
    end else if (exec && (st_ff == ST_DATA)) begin
      ptr_ff <= ptr_sum[4:0];
      if (ptr_sum[5]) sub_ff <= sub_ff + 3'h1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      blink_alt_eff_ff <= 1'b0;
    end else begin
      blink_alt_eff_ff <= blink_alt_ff && low_mux;
    end
  end

  lcdc_fifo #(
    .WIDTH (RAM_WR_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (fifo_push),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (push_word),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (!xfer_busy),
    .o_out_data  (fifo_out_data)
  );

  // Request toggle toward the link domain
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      hold_ff   <= '0;
      req_ff    <= 1'b0;
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
    end else begin
      ack_s1_ff <= link_ack_tgl;
      ack_s2_ff <= ack_s1_ff;
      if (fifo_pop) begin
        hold_ff <= lcdc_ram_wr_type'(fifo_out_data);
        req_ff  <= !req_ff;
      end
    end
  end

  lcdc_link_wr u_link_wr (
    .i_clk_link (i_clk_link),
    .i_link_rst (i_link_rst),
    .i_req_tgl  (req_ff),
    .i_word     (hold_ff),
    .o_ack_tgl  (link_ack_tgl),
    .o_ram_we   (o_ram_we),
    .o_ram_word (o_ram_word)
  );

  // Pin drive: open drain, low only
  assign o_sda_o            = 1'b0;
  assign o_sda_oe           = ack_ff;
  assign o_scl_o            = 1'b0;
  assign o_scl_oe           = pend_ff;
  assign o_display_en       = disp_en_ff;
  assign o_bias_half        = bias_ff;
  assign o_drive_mode       = mode_ff;
  assign o_in_bank          = in_bank_ff;
  assign o_out_bank         = out_bank_ff;
  assign o_blink_alt        = blink_alt_eff_ff;
  assign o_blink_rate_field = blink_rate_ff;
  assign o_data_ptr         = ptr_ff;
  assign o_subaddr_cnt      = sub_ff;
  assign o_selected         = (st_ff == ST_CMD) || (st_ff == ST_DATA);

  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  sequence s_addr_exec;
    exec && (st_ff == ST_ADDR) && !start_ev && !stop_ev;
  endsequence
  sequence s_cmd_exec;
    exec && (st_ff == ST_CMD) && !start_ev && !stop_ev;
  endsequence

  addr_hit_ack_a: assert property (s_addr_exec and addr_hit && addr_write
    |=> o_sda_oe && (st_ff == ST_CMD))
    else $error("matching address not acknowledged");
  read_no_ack_a: assert property (s_addr_exec and !addr_write
    |=> !o_sda_oe && (st_ff == ST_IGNORE))
    else $error("read request acknowledged");
  ignore_quiet_a: assert property ((st_ff == ST_IGNORE) && !start_ev
    |=> (st_ff != ST_CMD) && !o_sda_oe)
    else $error("ignored transfer became active");
  cmd_ack_a: assert property (s_cmd_exec |=> o_sda_oe)
    else $error("command byte not acknowledged");
  cont_flag_a: assert property (s_cmd_exec and !shift_ff[CONT_BIT]
    |=> st_ff == ST_DATA)
    else $error("last command did not enter data phase");
  data_ack_a: assert property (exec && (st_ff == ST_DATA) && !start_ev && !stop_ev
    |-> fifo_push == sub_match ##1 o_sda_oe == $past(sub_match))
    else $error("data acknowledge does not follow subaddress match");
  ptr_adv_a: assert property (exec && (st_ff == ST_DATA) && !start_ev && !stop_ev
    |=> ptr_ff == $past(ptr_sum[4:0]))
    else $error("data pointer did not advance");
  load_ptr_a: assert property (s_cmd_exec and is_load_ptr
    |=> ptr_ff == $past(shift_ff[4:0]))
    else $error("data pointer not loaded");
  mode_set_a: assert property (s_cmd_exec and is_mode_set
    |=> o_display_en == $past(shift_ff[MS_EN_BIT]) && o_drive_mode == $past(shift_ff[1:0]))
    else $error("mode-set fields not applied");
  start_rearm_a: assert property (start_ev |=> (st_ff == ST_ADDR) && !o_sda_oe ##1 !o_scl_oe)
    else $error("start did not re-arm address phase");
  byte_once_a: assert property (taken_ff && !start_ev && !stop_ev
    |=> !pend_ff)
    else $error("byte executed twice");
  dev_select_a: assert property (s_cmd_exec and is_dev_sel
    |=> o_subaddr_cnt == $past(shift_ff[2:0]))
    else $error("subaddress counter not loaded");
  bank_hold_a: assert property (s_cmd_exec and is_bank && !low_mux
    |=> $stable({o_in_bank, o_out_bank}))
    else $error("bank select acted in three or four backplane mode");
  blink_gate_a: assert property (!low_mux
    |=> !o_blink_alt)
    else $error("alternate bank blink shown in three or four backplane mode");
endmodule // lcdc_decoder
`default_nettype wire

// ---- verification/lcdc_i2c_master.sv ----
/*
  Behavioural two-wire bus master that drives the LCD command front end.
  Assumes the bench resolves both open-drain wires with pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none
module lcdc_i2c_master (
  // Clock and resolved wires
  input  wire logic i_clk_sys,
  input  wire logic i_scl,
  input  wire logic i_sda,
  // Pull-down requests and status
  output var logic  o_scl_low,
  output var logic  o_sda_low,
  output var logic  o_timeout
);
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
    o_timeout = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  // Release SCL, wait out stretching
  task automatic rise();
    int k;
    o_scl_low = 1'b0;
    for (k = 0; k < 5000 && i_scl !== 1'b1; k++) @(posedge i_clk_sys);
    if (i_scl !== 1'b1) o_timeout = 1'b1;
    hold(6);
  endtask
  task automatic start();
    o_sda_low = 1'b0;
    hold(3);
    rise();
    o_sda_low = 1'b1;
    hold(6);
    o_scl_low = 1'b1;
    hold(3);
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    hold(3);
    rise();
    o_sda_low = 1'b0;
    hold(6);
  endtask
  // MSB first, then the acknowledge slot
  task automatic wbyte(input logic [7:0] b, output logic ack);
    int i;
    for (i = 7; i >= 0; i--) begin
      o_sda_low = ~b[i];
      hold(3);
      rise();
      o_scl_low = 1'b1;
      hold(3);
    end
    o_sda_low = 1'b0;
    hold(3);
    rise();
    ack = ~i_sda;
    o_scl_low = 1'b1;
    hold(3);
  endtask
endmodule // lcdc_i2c_master
`default_nettype wire

// ---- verification/lcdc_decoder_test.sv ----
/*
  Self-checking bench for the LCD command decoder with a bus master model.
  Assumes pull-ups on both wires and a link clock that may be paused.
*/
`timescale 1ns/1ps
`default_nettype none
module lcdc_decoder_test import lcdc_pkg::*; ();
  logic clk_sys = 1'b0, clk_link = 1'b0, link_run = 1'b1, sys_rst, link_rst;
  logic scl, sda, m_scl_low, m_sda_low, m_timeout, strap, o_scl_oe, o_sda_oe, o_scl_o, o_sda_o;
  logic [2:0] pins;
  logic o_display_en, o_bias_half, o_in_bank, o_out_bank, o_blink_alt, o_selected, o_ram_we;
  logic [1:0] o_drive_mode, o_blink_rate_field;
  logic [4:0] o_data_ptr, p;
  logic [2:0] o_subaddr_cnt;
  logic [7:0] d;
  logic [31:0] seed = 32'h93683303, r;
  lcdc_ram_wr_type o_ram_word;
  lcdc_ram_wr_type exp_q[$];
  int num_errors = 0, compares = 0, i;
  always #4 clk_sys = ~clk_sys;
  initial #3 forever #15 clk_link = link_run ? ~clk_link : clk_link;
  assign scl = ~(m_scl_low | (o_scl_oe & ~o_scl_o));
  assign sda = ~(m_sda_low | (o_sda_oe & ~o_sda_o));
  lcdc_decoder lcdc_decoder_inst (.i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_clk_link(clk_link),
    .i_link_rst(link_rst), .i_scl(scl), .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe), .i_sda(sda), .o_sda_o(o_sda_o),
    .o_sda_oe(o_sda_oe), .i_addr_low_bit_strap(strap), .i_hw_subaddr_pin_bit0(pins[0]),
    .i_hw_subaddr_pin_bit1(pins[1]), .i_hw_subaddr_pin_bit2(pins[2]), .o_display_en(o_display_en),
    .o_bias_half(o_bias_half), .o_drive_mode(o_drive_mode), .o_in_bank(o_in_bank), .o_out_bank(o_out_bank),
    .o_blink_alt(o_blink_alt), .o_blink_rate_field(o_blink_rate_field), .o_data_ptr(o_data_ptr),
    .o_subaddr_cnt(o_subaddr_cnt), .o_selected(o_selected), .o_ram_we(o_ram_we), .o_ram_word(o_ram_word));
  lcdc_i2c_master lcdc_i2c_master_inst (.i_clk_sys(clk_sys), .i_scl(scl), .i_sda(sda),
    .o_scl_low(m_scl_low), .o_sda_low(m_sda_low), .o_timeout(m_timeout));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic put(input logic [7:0] b, input logic e);
    logic a;
    lcdc_i2c_master_inst.wbyte(b, a);
    chk("ack", 16'(e), 16'(a));
  endtask
  task automatic print_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // RAM write watcher
  always @(negedge clk_link) begin
    if (o_ram_we === 1'b1) begin
      if (exp_q.size() == 0) chk("ram_extra", 16'h0, 16'h1);
      else chk("ram_word", exp_q.pop_front(), o_ram_word);
    end
  end
  initial begin
    #400000;
    num_errors++;
    print_verdict();
  end
  initial begin
    sys_rst = 1'b1;
    link_rst = 1'b1;
    strap = 1'b1;
    pins = 3'h0;
    repeat (2) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    repeat (3) @(posedge clk_link);
    #1;
    link_rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    chk("drive_mode", 16'(RST_DRIVE_MODE), 16'(o_drive_mode));
    chk("data_ptr", 16'(RST_DATA_PTR), 16'(o_data_ptr));
    chk("subaddr", 16'(RST_SUBADDR), 16'(o_subaddr_cnt));
    chk("display_en", 16'h0, 16'(o_display_en));
    // Wrong address low bit, then a read request
    lcdc_i2c_master_inst.start();
    put(8'h70, 1'b0);
    put(8'h4D, 1'b0);
    chk("display_en", 16'h0, 16'(o_display_en));
    lcdc_i2c_master_inst.stop();
    lcdc_i2c_master_inst.start();
    put(8'h73, 1'b0);
    lcdc_i2c_master_inst.stop();
    // Static mode, chained commands
    lcdc_i2c_master_inst.start();
    put(8'h72, 1'b1);
    chk("selected", 16'h1, 16'(o_selected));
    put(8'hDD, 1'b1);
    chk("mode_set", 16'hD, 16'({o_display_en, o_bias_half, o_drive_mode}));
    for (i = 3; i >= 0; i--) begin
      put(8'hF8 | 8'(i), 1'b1);
      chk("banks", 16'(i), 16'({o_in_bank, o_out_bank}));
    end
    for (i = 0; i < 8; i++) begin
      put(8'hF0 | 8'(i), 1'b1);
      chk("blink", 16'(i), 16'({o_blink_alt, o_blink_rate_field}));
    end
    put(8'h85, 1'b1);
    chk("data_ptr", 16'h5, 16'(o_data_ptr));
    put(8'h60, 1'b1);
    chk("subaddr", 16'h0, 16'(o_subaddr_cnt));
    // Pointer wraps, counter moves off the pins
    p = 5'h05;
    for (i = 0; i < 5; i++) begin
      r = xs();
      d = r[7:0];
      if (i < 4) exp_q.push_back({p, d, 1'b0, DRIVE_STATIC});
      put(d, i < 4);
      p = p + STEP_STATIC[4:0];
    end
    chk("data_ptr", 16'(p), 16'(o_data_ptr));
    chk("subaddr", 16'h1, 16'(o_subaddr_cnt));
    // Repeated start into quad mode
    r = xs();
    pins = r[2:0];
    lcdc_i2c_master_inst.start();
    put(8'h72, 1'b1);
    put(8'hC8, 1'b1);
    chk("mode_set", 16'h8, 16'({o_display_en, o_bias_half, o_drive_mode}));
    put(8'hFB, 1'b1);
    chk("banks", 16'h0, 16'({o_in_bank, o_out_bank}));
    chk("blink_alt", 16'h0, 16'(o_blink_alt));
    put(8'h80, 1'b1);
    put(8'h60 | {5'h0, pins}, 1'b1);
    chk("subaddr", 16'(pins), 16'(o_subaddr_cnt));
    // Paused link clock fills the FIFO
    link_run = 1'b0;
    fork
      begin
        #8000;
        link_run = 1'b1;
      end
    join_none
    p = 5'h00;
    for (i = 0; i < 7; i++) begin
      r = xs();
      d = r[7:0];
      exp_q.push_back({p, d, 1'b0, DRIVE_QUAD});
      put(d, 1'b1);
      p = p + STEP_QUAD[4:0];
    end
    lcdc_i2c_master_inst.stop();
    chk("selected", 16'h0, 16'(o_selected));
    for (i = 0; i < 2000 && exp_q.size() > 0; i++) @(posedge clk_sys);
    chk("pending_writes", 16'h0, 16'(exp_q.size()));
    chk("stretch_timeout", 16'h0, 16'(m_timeout));
    print_verdict();
  end
endmodule // lcdc_decoder_test
`default_nettype wire
